// ===== core/mbf_pkg.sv
// Purpose: Constants for the back-off, deferral and address filter block
// Assumes: Wishbone word index offsets, 200 MHz clock, 100 Mb/s line (10 ns bit time)
// Notes:   Offsets are word indices; byte address is four times the index
`default_nettype none
package mbf_pkg;
   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [3:0]  REG_MAC_CTRL   = 4'h1;
   localparam logic [3:0]  REG_ADDR_UP    = 4'h2;
   localparam logic [3:0]  REG_ADDR_LO    = 4'h3;
   localparam logic [3:0]  REG_HASH_UP    = 4'h4;
   localparam logic [3:0]  REG_HASH_LO    = 4'h5;
   localparam logic [3:0]  REG_STATUS     = 4'h6;
   localparam logic [31:0] RST_ADDR_UP    = 32'h0000ffff;
   localparam logic [31:0] RST_ADDR_LO    = 32'h0fffffff;
   localparam logic [31:0] RST_HASH       = 32'h00000000;
   localparam logic [31:0] RST_CTRL       = 32'h00000000;
   // ************************************************************
   // Control fields
   // ************************************************************
   localparam int CTL_RX_ON      = 2;
   localparam int CTL_TX_ON      = 3;
   localparam int CTL_DEFER_CHK  = 5;
   localparam int CTL_CAP_LO     = 6;
   localparam int CTL_TABLE_SEL  = 13;
   localparam int CTL_TABLE_ONLY = 15;
   localparam int CTL_ALL_GROUP  = 19;
   localparam logic [15:0] ADDR_UP_MASK = 16'hffff;
   // ************************************************************
   // Back-off and deferral timing
   // ************************************************************
   localparam int          LFSR_W      = 20;
   localparam logic [19:0] LFSR_SEED   = 20'h00001;
   localparam logic [4:0]  K_MAX       = 5'h0a;
   localparam logic [4:0]  CAP_00      = 5'h0a;
   localparam logic [4:0]  CAP_01      = 5'h08;
   localparam logic [4:0]  CAP_10      = 5'h04;
   localparam logic [4:0]  CAP_11      = 5'h01;
   localparam int          CLK_MHZ     = 200;
   localparam int          BIT_NS      = 10;
   localparam int          CYC_PER_BIT = (BIT_NS * CLK_MHZ) / 1000;
   localparam int          SLOT_BITS   = 512;
   localparam int          SLOT_CYC    = SLOT_BITS * CYC_PER_BIT;
   localparam int          DEFER_BITS  = 24288;
   localparam int          DEFER_CYC   = DEFER_BITS * CYC_PER_BIT;
   localparam logic [31:0] CRC_POLY    = 32'hedb88320;
   localparam logic [31:0] CRC_INIT    = 32'hffffffff;
endpackage
`default_nettype wire

// ===== core/mbf_core.sv
// Purpose: Back-off, deferral watchdog, enables, station address and hash filter
// Assumes: Classic Wishbone slave, one clock, synchronous active high reset
// Notes:   Destination address arrives as a 48-bit word, first byte in bits 7:0
// Contract
// - Wait r slot times, 0 <= r < 2^K, K = min(retries, 10)
// - Random value comes from a free-running 20-bit LFSR
// - Load low K LFSR bits, decrement per slot time to zero, then retry
// - Cap field bits 7:6 limits bits to 10, 8, 4 or 1
// - One slot time is 512 bit times
// - With deferral check set, abort after deferring over 24288 bit times
// - Deferral timer runs only while ready and carrier busy; restarts each deferral
// - With deferral check clear, never abort on deferral
// - Transmit enable bit 3 gates all transmission
// - Receive enable bit 2 gates all reception
// - Upper address register holds bits 47:32, resets to 0000ffff
// - Lower address register holds address bits 31:0
// - EEPROM bytes 1-4 load lower register, bytes 5-6 upper register
// - Lower bits 7:0 match first received byte, upper 15:8 the sixth
// - Six-bit hash index: top bit picks register, five bits pick bit
// - Accept multicast when table bit set, or always with accept-all bit
// - Upper hash register is read-write, resets to zero
// - Table mode filters multicast by hash; table-only also unicast
// - Lower hash register at offset 5 is read-write, resets to zero
//
// The Wishbone register port was decided locally.
`default_nettype none
module mbf_core (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [5:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   // EEPROM preload
   input  wire logic        ee_load_i,
   input  wire logic [47:0] ee_addr_i,
   // Transmit side
   input  wire logic        tx_ready_i,
   input  wire logic        crs_i,
   input  wire logic        collision_i,
   input  wire logic [4:0]  retry_count_i,
   output logic             tx_go_o,
   output logic             backoff_busy_o,
   output logic             defer_abort_o,
   // Receive filter
   input  wire logic        rx_frame_i,
   input  wire logic [47:0] rx_dest_i,
   output logic             rx_accept_o,
   output logic             rx_valid_o
);
   // ************************************************************
   // State
   // ************************************************************
   typedef enum logic [1:0] {ST_IDLE, ST_BACKOFF, ST_DEFER} mbf_tx_t;
   typedef struct packed {
      logic [31:0] ctrl;
      logic [15:0] addr_up;
      logic [31:0] addr_lo;
      logic [31:0] hash_up;
      logic [31:0] hash_lo;
      logic [19:0] lfsr;
      logic [9:0]  slots;
      logic [15:0] slot_cnt;
      logic [17:0] defer_cnt;
      mbf_tx_t     tx_st;
      logic        ee_done;
      logic        abort;
      logic        ack;
      logic        err;
      logic [31:0] rdata;
      logic        accept;
      logic        rvalid;
   } mbf_state_t;

   mbf_state_t st_ff;
   mbf_state_t nxt_st;

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [31:0] mbf_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Serial CRC-32, LSB first as the bytes go out on the line
   function automatic logic [5:0] mbf_hash(input logic [47:0] da);
      logic [31:0] c;
      c = mbf_pkg::CRC_INIT;
      for (int i = 0; i < 48; i++) begin
         if (c[0] ^ da[i]) begin
            c = (c >> 1) ^ mbf_pkg::CRC_POLY;
         end else begin
            c = c >> 1;
         end
      end
      c = ~c;
      // Bit-reversed register: top six bits of the standard CRC sit at 0..5
      return {c[0], c[1], c[2], c[3], c[4], c[5]};
   endfunction

   // ************************************************************
   // Combinational next state
   // ************************************************************
   logic [4:0]  k_eff;
   logic [4:0]  cap;
   logic [9:0]  draw;
   logic [63:0] table_bits;
   logic [5:0]  hidx;
   logic        group_da;
   logic        perfect_hit;
   logic        hash_hit;
   logic        req;
   logic [3:0]  idx;

   always_comb begin
      nxt_st     = st_ff;
      nxt_st.ack = 1'b0;
      nxt_st.err = 1'b0;
      idx        = wb_adr_i[5:2];
      req        = wb_cyc_i && wb_stb_i && !st_ff.ack && !st_ff.err;

      // Free-running LFSR, taps 20 and 17
      nxt_st.lfsr = {st_ff.lfsr[18:0], st_ff.lfsr[19] ^ st_ff.lfsr[16]};

      // Power-on address preload
      if (!st_ff.ee_done) begin
         nxt_st.ee_done = 1'b1;
         if (ee_load_i) begin
            nxt_st.addr_lo = ee_addr_i[31:0];
            nxt_st.addr_up = ee_addr_i[47:32];
         end
      end

      // Register bus; one wait state, unmapped index answers err
      if (req) begin
         if (idx == mbf_pkg::REG_MAC_CTRL) begin
            nxt_st.ack   = 1'b1;
            nxt_st.rdata = st_ff.ctrl;
            if (wb_we_i) begin
               nxt_st.ctrl = mbf_merge(st_ff.ctrl, wb_dat_i, wb_sel_i);
            end
         end else if (idx == mbf_pkg::REG_ADDR_UP) begin
            nxt_st.ack   = 1'b1;
            nxt_st.rdata = {16'h0000, st_ff.addr_up};
            // Writes held off until preload is over
            if (wb_we_i && st_ff.ee_done) begin
               nxt_st.addr_up = 16'(mbf_merge({16'h0000, st_ff.addr_up}, wb_dat_i,
                                              wb_sel_i) & {16'h0000, mbf_pkg::ADDR_UP_MASK});
            end
         end else if (idx == mbf_pkg::REG_ADDR_LO) begin
            nxt_st.ack   = 1'b1;
            nxt_st.rdata = st_ff.addr_lo;
            if (wb_we_i && st_ff.ee_done) begin
               nxt_st.addr_lo = mbf_merge(st_ff.addr_lo, wb_dat_i, wb_sel_i);
            end
         end else if (idx == mbf_pkg::REG_HASH_UP) begin
            nxt_st.ack   = 1'b1;
            nxt_st.rdata = st_ff.hash_up;
            if (wb_we_i) begin
               nxt_st.hash_up = mbf_merge(st_ff.hash_up, wb_dat_i, wb_sel_i);
            end
         end else if (idx == mbf_pkg::REG_HASH_LO) begin
            nxt_st.ack   = 1'b1;
            nxt_st.rdata = st_ff.hash_lo;
            if (wb_we_i) begin
               nxt_st.hash_lo = mbf_merge(st_ff.hash_lo, wb_dat_i, wb_sel_i);
            end
         end else if (idx == mbf_pkg::REG_STATUS) begin
            nxt_st.ack   = 1'b1;
            nxt_st.rdata = {28'h0000000, st_ff.ee_done, st_ff.abort,
                            (st_ff.tx_st == ST_DEFER), (st_ff.tx_st == ST_BACKOFF)};
         end else begin
            nxt_st.err   = 1'b1;
            nxt_st.rdata = 32'h00000000;
         end
      end

      // Back-off draw: K = min(retries, 10), then min with cap
      k_eff = (retry_count_i < mbf_pkg::K_MAX) ? retry_count_i : mbf_pkg::K_MAX;
      case (st_ff.ctrl[mbf_pkg::CTL_CAP_LO +: 2])
         2'b00:   cap = mbf_pkg::CAP_00;
         2'b01:   cap = mbf_pkg::CAP_01;
         2'b10:   cap = mbf_pkg::CAP_10;
         default: cap = mbf_pkg::CAP_11;
      endcase
      if (cap < k_eff) begin
         k_eff = cap;
      end
      draw = st_ff.lfsr[9:0] & 10'((20'h00001 << k_eff) - 20'h00001);

      nxt_st.abort = 1'b0;
      case (st_ff.tx_st)
         ST_IDLE: begin
            nxt_st.defer_cnt = '0;
            if (collision_i) begin
               nxt_st.tx_st    = ST_BACKOFF;
               nxt_st.slots    = draw;
               nxt_st.slot_cnt = '0;
            end else if (tx_ready_i && crs_i && st_ff.ctrl[mbf_pkg::CTL_TX_ON]) begin
               nxt_st.tx_st = ST_DEFER;
            end
         end
         ST_BACKOFF: begin
            if (st_ff.slots == 10'h000) begin
               nxt_st.tx_st = ST_IDLE;
            end else if (st_ff.slot_cnt == 16'(mbf_pkg::SLOT_CYC - 1)) begin
               nxt_st.slot_cnt = '0;
               nxt_st.slots    = st_ff.slots - 10'h001;
            end else begin
               nxt_st.slot_cnt = st_ff.slot_cnt + 16'h0001;
            end
         end
         default: begin
            // Timer restarts from zero on every new deferral
            if (!(tx_ready_i && crs_i) || !st_ff.ctrl[mbf_pkg::CTL_TX_ON]) begin
               nxt_st.tx_st = ST_IDLE;
            end else if (st_ff.ctrl[mbf_pkg::CTL_DEFER_CHK] &&
                         st_ff.defer_cnt >= 18'(mbf_pkg::DEFER_CYC)) begin
               nxt_st.abort = 1'b1;
               nxt_st.tx_st = ST_IDLE;
            end else if (st_ff.defer_cnt < 18'(mbf_pkg::DEFER_CYC)) begin
               nxt_st.defer_cnt = st_ff.defer_cnt + 18'h00001;
            end
         end
      endcase

      // Receive address filter
      table_bits  = {st_ff.hash_up, st_ff.hash_lo};
      hidx        = mbf_hash(rx_dest_i);
      hash_hit    = table_bits[hidx];
      group_da    = rx_dest_i[0];
      perfect_hit = (rx_dest_i == {st_ff.addr_up, st_ff.addr_lo});
      nxt_st.rvalid = rx_frame_i && st_ff.ctrl[mbf_pkg::CTL_RX_ON];
      if (group_da) begin
         if (st_ff.ctrl[mbf_pkg::CTL_ALL_GROUP]) begin
            nxt_st.accept = 1'b1;
         end else if (st_ff.ctrl[mbf_pkg::CTL_TABLE_SEL]) begin
            nxt_st.accept = hash_hit;
         end else begin
            nxt_st.accept = perfect_hit;
         end
      end else if (st_ff.ctrl[mbf_pkg::CTL_TABLE_SEL] &&
                   st_ff.ctrl[mbf_pkg::CTL_TABLE_ONLY]) begin
         nxt_st.accept = hash_hit;
      end else begin
         nxt_st.accept = perfect_hit;
      end
      nxt_st.accept = nxt_st.accept && nxt_st.rvalid;
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff           <= '0;
         st_ff.ctrl      <= mbf_pkg::RST_CTRL;
         st_ff.addr_up   <= mbf_pkg::RST_ADDR_UP[15:0];
         st_ff.addr_lo   <= mbf_pkg::RST_ADDR_LO;
         st_ff.hash_up   <= mbf_pkg::RST_HASH;
         st_ff.hash_lo   <= mbf_pkg::RST_HASH;
         st_ff.lfsr      <= mbf_pkg::LFSR_SEED;
         st_ff.tx_st     <= ST_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign wb_dat_o       = st_ff.rdata;
   assign wb_ack_o       = st_ff.ack;
   assign wb_err_o       = st_ff.err;
   // Transmitter off means no attempt is ever released
   assign tx_go_o        = st_ff.ctrl[mbf_pkg::CTL_TX_ON] && tx_ready_i && !crs_i
                           && st_ff.tx_st == ST_IDLE && !collision_i;
   assign backoff_busy_o = (st_ff.tx_st == ST_BACKOFF);
   assign defer_abort_o  = st_ff.abort;
   assign rx_accept_o    = st_ff.accept;
   assign rx_valid_o     = st_ff.rvalid;

   // ************************************************************
   // Checks
   // ************************************************************
   // Checks read the state struct, so they follow the registers
   chk_tx_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      !st_ff.ctrl[mbf_pkg::CTL_TX_ON] |-> !tx_go_o)
      else $error("transmit released while disabled");
   chk_rx_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      !$past(st_ff.ctrl[mbf_pkg::CTL_RX_ON]) |-> !rx_accept_o && !rx_valid_o)
      else $error("frame accepted while receiver off");
   chk_no_abort_off: assert property (@(posedge clk_i) disable iff (rst_i)
      !$past(st_ff.ctrl[mbf_pkg::CTL_DEFER_CHK]) |-> !defer_abort_o)
      else $error("deferral abort with check disabled");
   chk_abort_late: assert property (@(posedge clk_i) disable iff (rst_i)
      defer_abort_o |-> $past(st_ff.defer_cnt) >= 18'(mbf_pkg::DEFER_CYC))
      else $error("deferral abort too early");
   chk_draw_bound: assert property (@(posedge clk_i) disable iff (rst_i)
      st_ff.tx_st == ST_IDLE && collision_i |=> st_ff.slots < (11'h001 << $past(k_eff)))
      else $error("back-off draw exceeds window");
   chk_slot_step: assert property (@(posedge clk_i) disable iff (rst_i)
      st_ff.tx_st == ST_BACKOFF && st_ff.slots != 10'h000 && st_ff.slot_cnt == 16'h0000
      |-> ##1 st_ff.slots == $past(st_ff.slots))
      else $error("slot ended early");
   chk_addr_reset: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> st_ff.addr_up == mbf_pkg::RST_ADDR_UP[15:0] &&
                       st_ff.hash_up == mbf_pkg::RST_HASH)
      else $error("address or hash reset value wrong");
   chk_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
   chk_all_group: assert property (@(posedge clk_i) disable iff (rst_i)
      rx_frame_i && rx_dest_i[0] && st_ff.ctrl[mbf_pkg::CTL_ALL_GROUP] &&
      st_ff.ctrl[mbf_pkg::CTL_RX_ON] |=> rx_accept_o)
      else $error("group frame dropped with accept-all");

   chk_defer_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      st_ff.tx_st != ST_DEFER |=> st_ff.defer_cnt == 18'h00000)
      else $error("deferral timer carried over");
   chk_abort_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      defer_abort_o |=> !defer_abort_o)
      else $error("deferral abort held two cycles");
   chk_cap_one: assert property (@(posedge clk_i) disable iff (rst_i)
      st_ff.tx_st == ST_IDLE && collision_i &&
      st_ff.ctrl[mbf_pkg::CTL_CAP_LO +: 2] == 2'b11 |=> st_ff.slots < 10'h002)
      else $error("one-bit cap drew more than one slot");
   chk_busy_entry: assert property (@(posedge clk_i) disable iff (rst_i)
      st_ff.tx_st == ST_IDLE && collision_i |=> backoff_busy_o)
      else $error("collision did not start back-off");
   chk_lfsr_live: assert property (@(posedge clk_i) disable iff (rst_i)
      st_ff.lfsr != 20'h00000)
      else $error("random source stuck at zero");
   chk_rx_source: assert property (@(posedge clk_i) disable iff (rst_i)
      rx_valid_o |-> $past(rx_frame_i))
      else $error("frame taken without a frame strobe");
   chk_accept_valid: assert property (@(posedge clk_i) disable iff (rst_i)
      rx_accept_o |-> rx_valid_o)
      else $error("frame accepted but not taken");
   chk_preload_once: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(st_ff.ee_done) |-> st_ff.ee_done)
      else $error("preload done flag dropped");
   chk_err_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_err_o |-> $past(wb_adr_i[5:2]) == 4'h0 || $past(wb_adr_i[5:2]) > mbf_pkg::REG_STATUS)
      else $error("error answer for a mapped register");

   // ************************************************************
   // Cover points
   // ************************************************************
   // One per main path, so a quiet bench shows up as missing hits
   cov_backoff: cover property (@(posedge clk_i) disable iff (rst_i)
      backoff_busy_o ##1 !backoff_busy_o);
   cov_abort:   cover property (@(posedge clk_i) disable iff (rst_i) defer_abort_o);
   cov_hash:    cover property (@(posedge clk_i) disable iff (rst_i)
      rx_accept_o && st_ff.ctrl[mbf_pkg::CTL_TABLE_SEL]);
   cov_only:    cover property (@(posedge clk_i) disable iff (rst_i)
      rx_accept_o && st_ff.ctrl[mbf_pkg::CTL_TABLE_ONLY]);
   cov_err:     cover property (@(posedge clk_i) disable iff (rst_i)
      wb_err_o);
endmodule
`default_nettype wire

// ===== verif/mbf_phy_model.sv
// Purpose: Line side model: carrier, collision and received destinations
// Assumes: Same clock as the block, changes just after rising edges
// Notes:   A released destination bus shows the inverse of its last value
`default_nettype none
module mbf_phy_model (
   // Clock
   input  wire logic        clk_i,
   // Line side
   output logic             crs_o,
   output logic             collision_o,
   output logic             rx_frame_o,
   output logic      [47:0] rx_dest_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      crs_o       = 1'b0;
      collision_o = 1'b0;
      rx_frame_o  = 1'b0;
      rx_dest_o   = 48'h0;
   end
   task automatic send(input logic [47:0] d);
      @(posedge clk_i);
      rx_frame_o <= 1'b1;
      rx_dest_o  <= d;
      @(posedge clk_i);
      rx_frame_o <= 1'b0;
      rx_dest_o  <= ~d; // Stale bus must never look valid
   endtask
   task automatic collide();
      @(posedge clk_i);
      collision_o <= 1'b1;
      @(posedge clk_i);
      collision_o <= 1'b0;
   endtask
   task automatic carrier(input logic on);
      @(posedge clk_i);
      crs_o <= on;
   endtask
endmodule
`default_nettype wire

// ===== verif/mac_backoff_address_filter_tb.sv
// Purpose: Self-checking bench for the back-off and address filter block
// Assumes: 200 MHz clock, classic Wishbone master, line model as partner
// Notes:   Deferral runs at full length, so the run is about 100k cycles
`default_nettype none
module mac_backoff_address_filter_tb;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic w; logic [3:0] i; logic [3:0] s; logic [31:0] d; logic [31:0] x; logic e;
   } mbf_row_t;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ee_load = 1'b0, tx_ready = 1'b0;
   logic [5:0]  adr = 6'h0;
   logic [3:0]  sel = 4'hf;
   logic [31:0] dat = 32'h0, rdat, q;
   logic [47:0] ee_addr = 48'h0, dest;
   logic [4:0]  retry = 5'h0;
   logic        ack, err, e, tx_go, busy, abort, crs, coll, rxf, rx_acc, rx_val;
   int          n_errors = 0, comparisons = 0, n;
   mbf_row_t    rows [17] = '{
      '{1'b0,4'h2,4'hf,32'h0,32'h0000ffff,1'b0}, '{1'b0,4'h3,4'hf,32'h0,32'h0fffffff,1'b0},
      '{1'b0,4'h4,4'hf,32'h0,32'h0,1'b0},        '{1'b0,4'h5,4'hf,32'h0,32'h0,1'b0},
      '{1'b1,4'h2,4'hf,32'hffffffff,32'h0,1'b0}, '{1'b0,4'h2,4'hf,32'h0,32'h0000ffff,1'b0},
      '{1'b1,4'h3,4'hf,32'h12345678,32'h0,1'b0}, '{1'b0,4'h3,4'hf,32'h0,32'h12345678,1'b0},
      '{1'b1,4'h4,4'h3,32'ha5a5a5a5,32'h0,1'b0}, '{1'b0,4'h4,4'hf,32'h0,32'h0000a5a5,1'b0},
      '{1'b1,4'h5,4'hf,32'hc3c3c3c3,32'h0,1'b0}, '{1'b0,4'h5,4'hf,32'h0,32'hc3c3c3c3,1'b0},
      '{1'b1,4'h1,4'h1,32'hffffffc4,32'h0,1'b0}, '{1'b0,4'h1,4'hf,32'h0,32'h000000c4,1'b0},
      '{1'b0,4'h6,4'hf,32'h0,32'h00000008,1'b0}, '{1'b0,4'h0,4'hf,32'h0,32'h0,1'b1},
      '{1'b0,4'h7,4'hf,32'h0,32'h0,1'b1}};
   always #2.5 clk_i = ~clk_i;
   mbf_core dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .wb_err_o(err), .ee_load_i(ee_load), .ee_addr_i(ee_addr), .tx_ready_i(tx_ready),
      .crs_i(crs), .collision_i(coll), .retry_count_i(retry), .tx_go_o(tx_go),
      .backoff_busy_o(busy), .defer_abort_o(abort), .rx_frame_i(rxf), .rx_dest_i(dest),
      .rx_accept_o(rx_acc), .rx_valid_o(rx_val));
   mbf_phy_model phy (
      .clk_i(clk_i), .crs_o(crs), .collision_o(coll), .rx_frame_o(rxf), .rx_dest_o(dest));
   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic stop_test();
      if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk32(input logic [31:0] g, input logic [31:0] x);
      comparisons++;
      if (g !== x) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic chk1(input logic g, input logic x);
      chk32({31'h0, g}, {31'h0, x});
   endtask
   // Holds the request until ack or err is sampled high
   task automatic wb(input logic w, input logic [3:0] i, input logic [3:0] s,
                     input logic [31:0] d, output logic [31:0] rq, output logic re);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= {i, 2'b00};
      sel <= s;
      dat <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && err !== 1'b1 && k < 50);
      rq = rdat;
      re = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (k >= 50) n_errors++;
   endtask
   task automatic wr(input logic [3:0] i, input logic [31:0] d);
      wb(1'b1, i, 4'hf, d, q, e);
   endtask
   task automatic do_reset(input logic ee);
      rst_i   <= 1'b1;
      ee_load <= ee;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
   task automatic rxchk(input logic [47:0] d, input logic xv, input logic xa);
      phy.send(d);
      #1;
      chk1(rx_val, xv);
      chk1(rx_acc, xa);
   endtask
   // Busy window must fit r slots of 1024 cycles, r below 2^K
   task automatic bo(input logic [31:0] c, input logic [4:0] rt, input int lim);
      int k;
      k = 0;
      retry <= rt;
      wr(4'h1, c);
      phy.collide();
      do begin
         @(posedge clk_i);
         k++;
      end while (busy === 1'b1 && k < lim + 10);
      chk1(k > 1 && k <= lim, 1'b1);
   endtask
   // ************************************************************
   // Sequence
   // ************************************************************
   initial begin
      repeat (105000) @(posedge clk_i);
      n_errors++;
      stop_test();
   end
   initial begin
      do_reset(1'b0);
      foreach (rows[k]) begin
         wb(rows[k].w, rows[k].i, rows[k].s, rows[k].d, q, e);
         chk1(e, rows[k].e);
         if (!rows[k].w && !rows[k].e) chk32(q, rows[k].x);
      end
      ee_addr <= 48'hbc9a78563412;
      do_reset(1'b1);
      wb(1'b0, 4'h3, 4'hf, 32'h0, q, e);
      chk32(q, 32'h78563412);
      wb(1'b0, 4'h2, 4'hf, 32'h0, q, e);
      chk32(q, 32'h0000bc9a);
      wr(4'h1, 32'h4);
      rxchk(48'hbc9a78563412, 1'b1, 1'b1);
      rxchk(48'h123456789abc, 1'b1, 1'b0);
      wr(4'h1, 32'h2004);
      rxchk(48'h5e0000000001, 1'b1, 1'b0);
      wr(4'h1, 32'h82004);
      rxchk(48'h5e0000000001, 1'b1, 1'b1);
      wr(4'h4, 32'hffffffff);
      wr(4'h5, 32'hffffffff);
      wr(4'h1, 32'h2004);
      rxchk(48'h5e0000000001, 1'b1, 1'b1);
      wr(4'h1, 32'ha004);
      rxchk(48'h123456789abc, 1'b1, 1'b1);
      wr(4'h4, 32'h0);
      wr(4'h5, 32'h0);
      rxchk(48'hbc9a78563412, 1'b1, 1'b0);
      wr(4'h1, 32'h0);
      rxchk(48'hbc9a78563412, 1'b0, 1'b0);
      tx_ready <= 1'b1;
      wr(4'h1, 32'h8);
      #1;
      chk1(tx_go, 1'b1);
      wr(4'h1, 32'h0);
      #1;
      chk1(tx_go, 1'b0);
      tx_ready <= 1'b0;
      bo(32'hc8, 5'd5, 1027);
      bo(32'h08, 5'd2, 3075);
      bo(32'h08, 5'd0, 3);
      wr(4'h1, 32'h28);
      tx_ready <= 1'b1;
      phy.carrier(1'b1);
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (abort !== 1'b1 && n < 48700);
      chk1(n > 48576 && n < 48585, 1'b1);
      phy.carrier(1'b0);
      wr(4'h1, 32'h08);
      phy.carrier(1'b1);
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (abort !== 1'b1 && n < 48600);
      chk32(32'(n), 32'd48600);
      stop_test();
   end
endmodule
`default_nettype wire
